// >>> design/dctg_trigger_gen.sv
// Dual camera trigger generator with Avalon-MM register access and shared sync pin.
//
// Functional notes
// - Two trigger outputs, each separately enabled; a disabled output stays low.
// - Primary trigger repeats periodically at a rate settable from 6 to 50 Hz.
// - Primary pulse high time is programmed in milliseconds.
// - Pulses are active high.
// - When selected, each primary rising edge time is supplied as frame timestamp.
// - Secondary trigger runs only while the primary trigger is enabled.
// - Secondary trigger always uses the primary repetition rate.
// - Secondary rising edge follows the primary rising edge by a programmed offset.
// - Secondary trigger has its own programmed pulse high time.
// - With pulse-per-second sync enabled, the secondary trigger is unavailable.
// - With pulse-per-second sync active, each sync pulse zeroes the timestamp clock.
// - Secondary output and sync input share one pin, used for one function only.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
module dctg_trigger_gen
  import dctg_pkg::*;
#(
  parameter int CLK_HZ     = CLK_HZ_DEF,
  parameter int CYC_PER_MS = CYC_PER_MS_DEF
)
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             trig0Out,
  output logic             sharedPinOut,
  output logic             sharedPinOe,
  input  wire logic        sharedPinIn,
  output logic [31:0]      frameStamp,
  output logic             frameStampStb
);

  // Longest period, used before the first period has been measured.
  localparam logic [31:0] MAX_PER = 32'(CLK_HZ / int'(FREQ_MIN_HZ));
  localparam logic [31:0] CLK_HZ_W = 32'(CLK_HZ);
  localparam logic [3:0]  US_LAST  = 4'(CYC_PER_US - 1);

  dctg_state_s s_q;
  dctg_state_s s_d;

  logic        pinLevel;
  logic        pinRise;
  logic [31:0] w0Cyc;
  logic [31:0] w1Cyc;
  logic [31:0] offCyc;
  logic [31:0] lim;
  logic [31:0] accSum;
  logic        wrap;
  logic        run1;
  logic        trig0Rise;

  function automatic logic [31:0] msToCyc(input logic [15:0] ms);
    msToCyc = 32'(32'(ms) * 32'(CYC_PER_MS));
  endfunction

  function automatic logic [31:0] mergeBe(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    end
    mergeBe = r;
  endfunction

  function automatic logic [5:0] clampFreq(input logic [31:0] v);
    if (v < 32'(FREQ_MIN_HZ))
      clampFreq = FREQ_MIN_HZ;
    else if (v > 32'(FREQ_MAX_HZ))
      clampFreq = FREQ_MAX_HZ;
    else
      clampFreq = v[5:0];
  endfunction

  dctg_pin_sync u_pin_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pinIn   (sharedPinIn),
    .level   (pinLevel),
    .rise    (pinRise)
  );

  // All pulse times are kept as clock cycle counts.
  assign w0Cyc  = msToCyc(s_q.cfg.w0);
  assign w1Cyc  = msToCyc(s_q.cfg.w1);
  assign offCyc = msToCyc(s_q.cfg.off);
  // The last cycle of a period is kept low so that the next rising edge is visible.
  assign lim    = s_q.lastPer - 32'd1;
  assign accSum = s_q.acc + 32'(s_q.cfg.freq);
  assign wrap   = accSum >= CLK_HZ_W;
  assign run1   = s_q.cfg.en0 & s_q.cfg.en1 & ~s_q.cfg.pps;

  always_comb
  begin
    s_d         = s_q;
    s_d.waitReq = 1'b1;
    trig0Rise   = 1'b0;

    // One access per request; waitrequest drops for exactly one cycle.
    if ((avs_read || avs_write) && s_q.waitReq)
    begin
      s_d.waitReq = 1'b0;
      if (avs_write)
      begin
        unique case (avs_address)
          OFS_CTRL:
          begin
            s_d.cfg.en0   = avs_byteenable[0] ? avs_writedata[CTRL_EN0_BIT] : s_q.cfg.en0;
            s_d.cfg.en1   = avs_byteenable[0] ? avs_writedata[CTRL_EN1_BIT] : s_q.cfg.en1;
            s_d.cfg.pps   = avs_byteenable[0] ? avs_writedata[CTRL_PPS_BIT] : s_q.cfg.pps;
            s_d.cfg.tsSel = avs_byteenable[0] ? avs_writedata[CTRL_TSSEL_BIT] : s_q.cfg.tsSel;
          end
          OFS_FREQ:
            s_d.cfg.freq = clampFreq(mergeBe(32'(s_q.cfg.freq), avs_writedata, avs_byteenable));
          OFS_WIDTH0:
            s_d.cfg.w0 = 16'(mergeBe(32'(s_q.cfg.w0), avs_writedata, avs_byteenable));
          OFS_WIDTH1:
            s_d.cfg.w1 = 16'(mergeBe(32'(s_q.cfg.w1), avs_writedata, avs_byteenable));
          OFS_OFFSET:
            s_d.cfg.off = 16'(mergeBe(32'(s_q.cfg.off), avs_writedata, avs_byteenable));
          default:
            s_d.cfg = s_q.cfg;
        endcase
      end
      else
      begin
        unique case (avs_address)
          OFS_CTRL:
            s_d.rdata = {28'h000_0000, s_q.cfg.tsSel, s_q.cfg.pps, s_q.cfg.en1, s_q.cfg.en0};
          OFS_FREQ:
            s_d.rdata = 32'(s_q.cfg.freq);
          OFS_WIDTH0:
            s_d.rdata = 32'(s_q.cfg.w0);
          OFS_WIDTH1:
            s_d.rdata = 32'(s_q.cfg.w1);
          OFS_OFFSET:
            s_d.rdata = 32'(s_q.cfg.off);
          OFS_STATUS:
            s_d.rdata = 32'({pinLevel & s_q.cfg.pps, s_q.cfg.pps, s_q.trig1, s_q.trig0});
          OFS_TSNOW:
            s_d.rdata = s_q.tsNow;
          OFS_TSTRIG:
            s_d.rdata = s_q.tsTrig;
          default:
            s_d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // A fractional accumulator gives an exact average rate without a divider.
    if (!s_q.cfg.en0)
    begin
      s_d.acc = 32'h0000_0000;
      s_d.pos = 32'h0000_0000;
    end
    else if (wrap)
    begin
      s_d.acc     = accSum - CLK_HZ_W;
      s_d.pos     = 32'h0000_0000;
      s_d.lastPer = s_q.pos + 32'd1;
    end
    else
    begin
      s_d.acc = accSum;
      s_d.pos = s_q.pos + 32'd1;
    end

    // Both outputs follow one period counter, so their rates cannot differ.
    // A pulse may only begin at its own start point, so a width change never makes a stray edge.
    s_d.trig0 = s_q.cfg.en0 && (s_q.pos == 32'd0 || s_q.trig0) && (s_q.pos < w0Cyc) && (s_q.pos < lim);
    s_d.trig1 = run1 && (s_q.pos == offCyc || s_q.trig1) && (s_q.pos >= offCyc)
                && (s_q.pos < offCyc + w1Cyc) && (s_q.pos < lim);

    // The pin is an input while sync is on and an output otherwise.
    s_d.pinOe = ~s_q.cfg.pps;

    trig0Rise = s_d.trig0 & ~s_q.trig0;
    s_d.stb   = trig0Rise & s_q.cfg.tsSel;
    if (trig0Rise)
      s_d.tsTrig = s_q.tsNow;

    // Microsecond timestamp clock; a sync edge restarts it from zero.
    if (s_q.cfg.pps && pinRise)
    begin
      s_d.tsNow = 32'h0000_0000;
      s_d.usCnt = 4'h0;
    end
    else if (s_q.usCnt == US_LAST)
    begin
      s_d.usCnt = 4'h0;
      s_d.tsNow = s_q.tsNow + 32'd1;
    end
    else
      s_d.usCnt = s_q.usCnt + 4'h1;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q          <= '0;
      s_q.cfg.freq <= FREQ_RST;
      s_q.cfg.w0   <= WIDTH0_RST;
      s_q.cfg.w1   <= WIDTH1_RST;
      s_q.cfg.off  <= OFFSET_RST;
      s_q.lastPer  <= MAX_PER;
      s_q.pinOe    <= 1'b1;
      s_q.waitReq  <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = s_q.waitReq;
  assign trig0Out        = s_q.trig0;
  // Driving low whenever the secondary is idle outside sync mode keeps the camera input defined.
  assign sharedPinOut    = s_q.trig1;
  assign sharedPinOe     = s_q.pinOe;
  assign frameStamp      = s_q.tsTrig;
  assign frameStampStb   = s_q.stb;

  disabledLow_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !s_q.cfg.en0 |=> !trig0Out)
    else $error("Primary trigger high while disabled.");

  freqRange_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.cfg.freq >= FREQ_MIN_HZ && s_q.cfg.freq <= FREQ_MAX_HZ)
    else $error("Trigger rate outside its range.");

  riseAtStart_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(trig0Out) |-> $past(s_q.pos) == 32'd0)
    else $error("Primary trigger rose away from period start.");

  stampOnRise_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    frameStampStb |-> $rose(trig0Out) && frameStamp == $past(s_q.tsNow))
    else $error("Frame timestamp strobe not tied to trigger edge.");

  secNeedsPri_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sharedPinOut |-> $past(s_q.cfg.en0) && $past(s_q.cfg.en1))
    else $error("Secondary trigger active without primary.");

  secOffset_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(sharedPinOut) |-> $past(s_q.pos) == $past(offCyc))
    else $error("Secondary rising edge not at programmed offset.");

  ppsBlocks_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.cfg.pps |=> !sharedPinOe && !sharedPinOut)
    else $error("Shared pin driven while sync is enabled.");

  ppsZero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.cfg.pps && pinRise |=> s_q.tsNow == 32'd0 ##[10:10] s_q.tsNow == 32'd1)
    else $error("Timestamp clock not restarted by sync pulse.");

  pulseEnds_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sharedPinOut || trig0Out |-> $past(s_q.pos) < $past(lim))
    else $error("Pulse runs into the last cycle of a period.");

  busWait_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("Waitrequest low for more than one cycle.");

  secDisabled_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !s_q.cfg.en1 |=> !sharedPinOut)
    else $error("Secondary trigger high while disabled.");

  priNeedsEn_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    trig0Out |-> $past(s_q.cfg.en0))
    else $error("Primary trigger high without enable.");

  pinOeMode_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sharedPinOe != $past(s_q.cfg.pps))
    else $error("Shared pin direction does not follow sync mode.");

  secNoPps_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sharedPinOut |-> !$past(s_q.cfg.pps))
    else $error("Secondary trigger active in sync mode.");

  secStart_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sharedPinOut |-> $past(s_q.pos) >= $past(offCyc))
    else $error("Secondary trigger high before its offset.");

  secWidth_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sharedPinOut |-> $past(s_q.pos) < $past(offCyc) + $past(w1Cyc))
    else $error("Secondary trigger high past its width.");

  priWidth_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    trig0Out |-> $past(s_q.pos) < $past(w0Cyc))
    else $error("Primary trigger high past its width.");

  stampSel_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    frameStampStb |-> $past(s_q.cfg.tsSel))
    else $error("Frame timestamp strobe while not selected.");

  stampHold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !$rose(trig0Out) |-> $stable(frameStamp))
    else $error("Frame timestamp changed away from a trigger edge.");

  tsSteady_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(s_q.cfg.pps && pinRise) && s_q.usCnt != US_LAST |=> $stable(s_q.tsNow))
    else $error("Timestamp clock moved between ticks.");

  usTick_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.usCnt == US_LAST && !(s_q.cfg.pps && pinRise) |=> s_q.tsNow == $past(s_q.tsNow) + 32'd1)
    else $error("Timestamp clock missed a tick.");

  posIdle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !s_q.cfg.en0 |=> s_q.pos == 32'd0)
    else $error("Period counter runs while disabled.");

  periodWrap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.cfg.en0 && wrap |=> s_q.pos == 32'd0 && s_q.lastPer == $past(s_q.pos) + 32'd1)
    else $error("Period not restarted at accumulator wrap.");

  accBound_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.acc < CLK_HZ_W)
    else $error("Rate accumulator out of range.");

  busAnswer_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus request not answered in one cycle.");

  busIdle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !avs_read && !avs_write |=> avs_waitrequest)
    else $error("Waitrequest low without a request.");

  rdataHold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(avs_read && !avs_write && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("Read data changed without a read.");

  cfgHold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(avs_write && avs_waitrequest) |=> $stable(s_q.cfg))
    else $error("Settings changed without a write.");

endmodule

// >>> design/dctg_pkg.sv
// Shared constants, register map and state types of the dual camera trigger generator.
package dctg_pkg;

  // Clock and time units.
  localparam int CLK_PERIOD_NS  = 100;
  localparam int NS_PER_S       = 1_000_000_000;
  localparam int CLK_HZ_DEF     = NS_PER_S / CLK_PERIOD_NS;
  localparam int MS_NS          = 1_000_000;
  localparam int US_NS          = 1_000;
  localparam int CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int CYC_PER_US     = US_NS / CLK_PERIOD_NS;

  // Primary trigger repetition rate limits in hertz.
  localparam logic [5:0] FREQ_MIN_HZ = 6'h06;
  localparam logic [5:0] FREQ_MAX_HZ = 6'h32;

  // Register byte offsets.
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_FREQ   = 5'h04;
  localparam logic [4:0] OFS_WIDTH0 = 5'h08;
  localparam logic [4:0] OFS_WIDTH1 = 5'h0C;
  localparam logic [4:0] OFS_OFFSET = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_TSNOW  = 5'h18;
  localparam logic [4:0] OFS_TSTRIG = 5'h1C;

  // Control register bit positions.
  localparam int CTRL_EN0_BIT   = 0;
  localparam int CTRL_EN1_BIT   = 1;
  localparam int CTRL_PPS_BIT   = 2;
  localparam int CTRL_TSSEL_BIT = 3;

  // Status register bit positions.
  localparam int STAT_TRIG0_BIT = 0;
  localparam int STAT_TRIG1_BIT = 1;
  localparam int STAT_PPS_BIT   = 2;
  localparam int STAT_PIN_BIT   = 3;

  // Reset values.
  localparam logic [5:0]  FREQ_RST   = 6'h1E;
  localparam logic [15:0] WIDTH0_RST = 16'h0005;
  localparam logic [15:0] WIDTH1_RST = 16'h0005;
  localparam logic [15:0] OFFSET_RST = 16'h0000;

  typedef struct packed {
    logic        en0;
    logic        en1;
    logic        pps;
    logic        tsSel;
    logic [5:0]  freq;
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] off;
  } dctg_cfg_s;

  typedef struct packed {
    dctg_cfg_s   cfg;
    logic [31:0] acc;
    logic [31:0] pos;
    logic [31:0] lastPer;
    logic [31:0] tsNow;
    logic [31:0] tsTrig;
    logic [31:0] rdata;
    logic [3:0]  usCnt;
    logic        trig0;
    logic        trig1;
    logic        pinOe;
    logic        stb;
    logic        waitReq;
  } dctg_state_s;

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } dctg_sync_s;

endpackage

// >>> design/dctg_pin_sync.sv
// Two-stage synchroniser with rising-edge detection for the shared pin input.
`timescale 1ns/1ns
module dctg_pin_sync
  import dctg_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise
);

  dctg_sync_s s_q;
  dctg_sync_s s_d;

  // Only the second stage and its delayed copy feed the edge logic.
  always_comb
  begin
    s_d      = s_q;
    s_d.meta = pinIn;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign level = s_q.sync;
  assign rise  = s_q.sync & ~s_q.prev;

endmodule

// >>> dv/dctg_cam_model.sv
// Behavioural camera pair that measures the trigger pulses it receives.
`timescale 1ns/1ns
module dctg_cam_model
  import dctg_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic trig0,
  input  wire logic pinLvl,
  input  wire logic pinOe,
  output int        rise0,
  output int        rise1,
  output int        hi0,
  output int        hi1,
  output int        per0,
  output int        per1,
  output int        dly
);
  logic t1;
  logic p0 = 1'b0;
  logic p1 = 1'b0;
  int   c0;
  int   c1;
  int   t;
  int   u;

  // The secondary camera only sees a trigger while the block drives the shared pin.
  assign t1 = pinOe & pinLvl;

  // A capture starts on every rising edge; none is skipped, so stamps stay paired.
  always @(posedge clk_sys)
  begin
    p0 <= trig0;
    p1 <= t1;
    t <= t + 1;
    u <= u + 1;
    if (trig0 && !p0)
    begin
      rise0 <= rise0 + 1;
      per0 <= t;
      t <= 1;
    end
    if (t1 && !p1)
    begin
      rise1 <= rise1 + 1;
      dly <= t;
      per1 <= u;
      u <= 1;
    end
    c0 <= trig0 ? c0 + 1 : 0;
    c1 <= t1 ? c1 + 1 : 0;
    if (!trig0 && c0 != 0)
      hi0 <= c0;
    if (!t1 && c1 != 0)
      hi1 <= c1;
  end
endmodule

// >>> dv/tb_dual_camera_trigger_generator.sv
// Self-checking bench for the dual camera trigger generator.
`timescale 1ns/1ns
module tb_dual_camera_trigger_generator
  import dctg_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        nrst    = 1'b0;
  logic [4:0]  addr    = 5'h00;
  logic        rdEn    = 1'b0;
  logic        wrEn    = 1'b0;
  logic        ppsLvl  = 1'b0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [31:0] stamp;
  logic [31:0] sPrev   = 32'h0000_0000;
  logic [31:0] sGap    = 32'h0000_0000;
  logic        waitReq;
  logic        trig0;
  logic        pOut;
  logic        pOe;
  logic        stb;
  logic        pin;
  int          errors  = 0;
  int          checked = 0;
  int          cyc     = 0;
  int          stbN    = 0;
  int          s0;
  int          r0;
  int          rise0, rise1, hi0, hi1, per0, per1, dly;

  // The bench stands in for the sync source whenever the block releases the pin.
  assign pin = pOe ? pOut : ppsLvl;

  initial forever #50 clk_sys = ~clk_sys;

  dctg_trigger_gen #(.CLK_HZ(100), .CYC_PER_MS(1)) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .avs_address(addr), .avs_read(rdEn), .avs_write(wrEn),
    .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(waitReq),
    .trig0Out(trig0), .sharedPinOut(pOut), .sharedPinOe(pOe), .sharedPinIn(pin),
    .frameStamp(stamp), .frameStampStb(stb));

  dctg_cam_model cam_u (
    .clk_sys(clk_sys), .trig0(trig0), .pinLvl(pin), .pinOe(pOe), .rise0(rise0), .rise1(rise1),
    .hi0(hi0), .hi1(hi1), .per0(per0), .per1(per1), .dly(dly));

  task end_of_test;
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus cycle; entered just after a rising edge, held until waitrequest is seen low.
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wrEn <= w;
    rdEn <= !w;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (waitReq !== 1'b0 && n < 50);
    v = rdata;
    if (n >= 50)
      errors++;
    wrEn <= 1'b0;
    rdEn <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  always @(posedge clk_sys)
  begin
    if (stb === 1'b1)
    begin
      stbN  <= stbN + 1;
      sPrev <= stamp;
      sGap  <= stamp - sPrev;
    end
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      end_of_test;
    end
  end

  initial
  begin
    wt(8);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk(trig0, 1'b0);
    chk(pOe, 1'b1);
    acc(1'b0, OFS_FREQ, 32'h0000_0000);
    chk(v, 32'h0000_001E);
    acc(1'b1, OFS_FREQ, 32'h0000_0002);
    acc(1'b0, OFS_FREQ, 32'h0000_0000);
    chk(v, 32'h0000_0006);
    acc(1'b1, OFS_FREQ, 32'h0000_003C);
    acc(1'b0, OFS_FREQ, 32'h0000_0000);
    chk(v, 32'h0000_0032);
    // Rate 10 Hz at a 100 Hz model clock gives a 10 cycle period with no jitter.
    acc(1'b1, OFS_FREQ, 32'h0000_000A);
    acc(1'b1, OFS_WIDTH0, 32'h0000_0003);
    acc(1'b1, OFS_WIDTH1, 32'h0000_0004);
    acc(1'b1, OFS_OFFSET, 32'h0000_0002);
    acc(1'b1, OFS_CTRL, 32'h0000_000B);
    wt(40);
    s0 = stbN;
    r0 = rise0;
    wt(30);
    chk(rise0 - r0, 32'h0000_0003);
    chk(stbN - s0, 32'h0000_0003);
    chk(sGap, 32'h0000_0001);
    chk(per0, 32'h0000_000A);
    chk(per1, 32'h0000_000A);
    chk(hi0, 32'h0000_0003);
    chk(dly, 32'h0000_0002);
    chk(hi1, 32'h0000_0004);
    acc(1'b1, OFS_WIDTH0, 32'h0000_0014);
    wt(25);
    chk(hi0, 32'h0000_0009);
    acc(1'b1, OFS_OFFSET, 32'h0000_0000);
    acc(1'b1, OFS_CTRL, 32'h0000_0002);
    wt(15);
    r0 = rise1;
    wt(25);
    chk(rise1 - r0, 32'h0000_0000);
    chk(pOut, 1'b0);
    chk(trig0, 1'b0);
    acc(1'b1, OFS_CTRL, 32'h0000_0007);
    wt(3);
    chk(pOe, 1'b0);
    ppsLvl <= 1'b1;
    wt(5);
    acc(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(v[3], 1'b1);
    acc(1'b0, OFS_TSNOW, 32'h0000_0000);
    chk(v < 32'h0000_0002, 1'b1);
    ppsLvl <= 1'b0;
    wt(12);
    end_of_test;
  end
endmodule
